// *** inc/mrs_link_if.sv ***
// Discrete input link between controller and motor sequencer
interface mrs_link_if;
  logic forward_run_input;
  logic reverse_run_input;
  logic data_select_bit0;
  logic data_select_bit1;
  logic brake_free_input;
  logic motor_running;

  modport dev (
    input forward_run_input,
    input reverse_run_input,
    input data_select_bit0,
    input data_select_bit1,
    input brake_free_input,
    output motor_running
  );

  modport ctl (
    output forward_run_input,
    output reverse_run_input,
    output data_select_bit0,
    output data_select_bit1,
    output brake_free_input,
    input motor_running
  );
endinterface

// *** inc/mrs_params.svh ***
// Timing counts, offsets and field positions for the run ramp sequencer
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------
`define MRS_CLK_MHZ 250
`define MRS_TICK_US 1000
`define MRS_TICK_CYCLES (`MRS_TICK_US * `MRS_CLK_MHZ)

// ----------------------------------------------------------------
// Times in milliseconds, counted in timebase ticks
// ----------------------------------------------------------------
`define MRS_BRAKE_HOLD_MS 100
`define MRS_INSTOP_MS 400
`define MRS_MIN_ON_MS 10
`define MRS_FILTER_MS 5

// ----------------------------------------------------------------
// Ramp settings, times in tenths of a second
// ----------------------------------------------------------------
`define MRS_TIME_MIN_DECEL_ON 8'h02
`define MRS_TIME_MIN_DECEL_OFF 8'h00
`define MRS_TIME_MAX 8'h96
`define MRS_MS_PER_TENTH 16'h0064
`define MRS_REMOTE_REF_RPM 16'h03E8

// ----------------------------------------------------------------
// Controller register map and fields
// ----------------------------------------------------------------
`define MRS_REG_CMD 4'h0
`define MRS_REG_STATUS 4'h4
`define MRS_CMD_RESET 5'h00
`define MRS_CMD_FWD 0
`define MRS_CMD_REV 1
`define MRS_CMD_SEL0 2
`define MRS_CMD_SEL1 3
`define MRS_CMD_FREE 4
`define MRS_STAT_PENDING 8
`define MRS_STAT_RUNNING 9

`endif

// *** inc/mrs_pkg.sv ***
// Types shared by both ends of the run ramp sequencer
package mrs_pkg;
  typedef logic [15:0] mrs_rpm_t;
  typedef logic [7:0] mrs_time_t;
  typedef logic [1:0] mrs_sel_t;
  typedef enum logic [2:0] {
    MRS_ST_IDLE = 3'b000,
    MRS_ST_RUN = 3'b001,
    MRS_ST_DECEL = 3'b010,
    MRS_ST_INSTOP = 3'b011,
    MRS_ST_HOLD = 3'b100
  } mrs_state_t;
endpackage

// *** src/mrs_controller.sv ***
// Controller end: AXI4-Lite command registers driving the discrete run inputs
`include "mrs_params.svh"

module mrs_controller #(
  parameter int TICK_CYCLES = `MRS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link to device
  mrs_link_if.ctl link,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mrs_pkg::*;

  // ----------------------------------------------------------------
  // Timebase and minimum hold
  // ----------------------------------------------------------------
  logic [17:0] div_r;
  logic tick;
  logic [3:0] held_r;
  logic [4:0] cmd_r;
  logic [4:0] out_r;
  logic hold_ok;
  logic running_m_r;
  logic running_r;

  always_ff @(posedge clock) begin
    if (!resetn || tick) begin
      div_r <= 18'h00000;
    end else begin
      div_r <= div_r + 18'h00001;
    end
  end
  assign tick = (div_r == 18'(TICK_CYCLES - 1));
  assign hold_ok = (held_r == 4'(`MRS_MIN_ON_MS));

  // New levels wait until the previous ones stood 10 ms, so no edge is too short to see
  always_ff @(posedge clock) begin
    if (!resetn) begin
      out_r <= `MRS_CMD_RESET;
      held_r <= 4'h0;
    end else if (hold_ok && cmd_r != out_r) begin
      out_r <= cmd_r; // RQ7
      held_r <= 4'h0;
    end else if (tick && !hold_ok) begin
      held_r <= held_r + 4'h1;
    end
  end

  assign link.forward_run_input = out_r[`MRS_CMD_FWD];
  assign link.reverse_run_input = out_r[`MRS_CMD_REV];
  assign link.data_select_bit0 = out_r[`MRS_CMD_SEL0]; // RQ13
  assign link.data_select_bit1 = out_r[`MRS_CMD_SEL1];
  assign link.brake_free_input = out_r[`MRS_CMD_FREE];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      running_m_r <= 1'b0;
      running_r <= 1'b0;
    end else begin
      running_m_r <= link.motor_running;
      running_r <= running_m_r;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cmd_r <= `MRS_CMD_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (s_axi_awaddr[3:2] == `MRS_REG_CMD >> 2) begin
        s_axi_bresp <= 2'h0;
        if (s_axi_wstrb[0]) begin
          cmd_r <= s_axi_wdata[4:0];
        end
      end else begin
        s_axi_bresp <= 2'h2;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr[3:2] == `MRS_REG_CMD >> 2) begin
        s_axi_rdata <= {27'h0000000, cmd_r};
      end else if (s_axi_araddr[3:2] == `MRS_REG_STATUS >> 2) begin
        s_axi_rdata <= {22'h000000, running_r, cmd_r != out_r, 3'h0, out_r};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** src/mrs_device.sv ***
// Motor run sequencer: input filter, entry select, ramp engine, stop and brake sequencing
// Summary of operation
// [RQ1] Ramp times limited 0.2 to 15.0 s
// [RQ2] Decel control off: lower limit 0.0 s
// [RQ3] Panel speed: time spans current to target
// [RQ4] Remote speed: time spans 0 to 1000 r/min
// [RQ5] Direction setting swaps forward shaft direction
// [RQ6] Brake hold 0.1 s only with decel control
// [RQ7] Controller holds each input 10 ms minimum
// [RQ8] Instantaneous stop brakes actively for 0.4 s
// [RQ9] Brake free input releases the brake
// [RQ10] Select bits pick entry 0 to 3
// [RQ11] Drive with selected entry speed and ramps
// [RQ12] External command feeds entry 0 only
// [RQ13] Entry change while running re-ramps to it
// [RQ14] Decel control off: no downhill regulation
// [RQ15] Vertical use keeps speed 300 to 1400/1600; entry and external speeds are used unlimited here
// [RQ16] Vertical use keeps deceleration stop mode; ramp_down_stop_mode is a free input here
// [RQ17] Run input released: ramp down to stop
// [RQ18] Both run inputs: instantaneous stop
// [RQ19] Inputs synchronised and filtered on ms tick
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`include "mrs_params.svh"

module mrs_device #(
  parameter int TICK_CYCLES = `MRS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link to controller
  mrs_link_if.dev link,
  // Configuration
  input wire logic decel_ctrl_en,
  input wire logic dir_swap,
  input wire logic ext_speed_en,
  input wire logic ramp_down_stop_mode,
  // Operation data
  input mrs_pkg::mrs_rpm_t entry_speed [4],
  input mrs_pkg::mrs_time_t entry_accel [4],
  input mrs_pkg::mrs_time_t entry_decel [4],
  input mrs_pkg::mrs_rpm_t ext_speed_rpm,
  // Motor outputs
  output mrs_pkg::mrs_rpm_t speed_rpm,
  output logic dir_reverse,
  output logic drive_on,
  output logic active_brake,
  output logic brake_release,
  output logic speed_regulate,
  output mrs_pkg::mrs_sel_t selected_entry,
  output mrs_pkg::mrs_state_t state
);
  import mrs_pkg::*;

  // ----------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------
  logic [17:0] div_r;
  logic tick;

  always_ff @(posedge clock) begin
    if (!resetn || tick) begin
      div_r <= 18'h00000;
    end else begin
      div_r <= div_r + 18'h00001;
    end
  end
  assign tick = (div_r == 18'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // Input synchroniser and filter
  // ----------------------------------------------------------------
  logic [4:0] raw;
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic [4:0] filt_r;

  assign raw = {link.brake_free_input, link.data_select_bit1, link.data_select_bit0,
                link.reverse_run_input, link.forward_run_input};

  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
    end else begin
      meta_r <= raw; // RQ19
      sync_r <= meta_r;
    end
  end

  // A level must stay put for a few ticks; shorter than the 10 ms hold the controller keeps
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      logic [3:0] cnt_r;
      always_ff @(posedge clock) begin
        if (!resetn) begin
          cnt_r <= 4'h0;
          filt_r[gi] <= 1'b0;
        end else if (sync_r[gi] == filt_r[gi]) begin
          cnt_r <= 4'h0;
        end else if (tick) begin
          if (cnt_r == 4'(`MRS_FILTER_MS - 1)) begin // RQ19 RQ7
            filt_r[gi] <= sync_r[gi];
            cnt_r <= 4'h0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      end
    end
  endgenerate

  logic f_fwd;
  logic f_rev;
  logic f_free;
  logic one_run;
  logic both_run;
  logic req_dir;
  assign f_fwd = filt_r[0];
  assign f_rev = filt_r[1];
  assign f_free = filt_r[4];
  assign one_run = f_fwd ^ f_rev;
  assign both_run = f_fwd & f_rev;
  assign req_dir = f_rev ^ dir_swap; // RQ5

  // ----------------------------------------------------------------
  // Entry selection
  // ----------------------------------------------------------------
  mrs_sel_t sel;
  logic remote;
  mrs_rpm_t tgt_rpm;
  assign sel = filt_r[3:2]; // RQ10
  assign remote = (sel == 2'h0) && ext_speed_en; // RQ12
  assign tgt_rpm = remote ? ext_speed_rpm : entry_speed[sel]; // RQ11 RQ13

  // Out-of-range settings are clamped rather than rejected
  function automatic mrs_time_t clamp_time(input mrs_time_t t, input logic dc_en);
    mrs_time_t lo;
    lo = dc_en ? `MRS_TIME_MIN_DECEL_ON : `MRS_TIME_MIN_DECEL_OFF; // RQ1 RQ2
    if (t < lo) begin
      clamp_time = lo;
    end else if (t > `MRS_TIME_MAX) begin
      clamp_time = `MRS_TIME_MAX;
    end else begin
      clamp_time = t;
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mrs_state_t state_r;
  mrs_state_t state_nxt;
  logic dir_r;
  logic [8:0] tmr_r;
  mrs_rpm_t spd_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MRS_ST_IDLE: begin
        if (one_run) begin
          state_nxt = MRS_ST_RUN;
        end
      end
      MRS_ST_RUN: begin
        if (both_run) begin
          state_nxt = MRS_ST_INSTOP; // RQ18
        end else if (!one_run) begin
          state_nxt = ramp_down_stop_mode ? MRS_ST_DECEL : MRS_ST_IDLE; // RQ17
        end
      end
      MRS_ST_DECEL: begin
        if (both_run) begin
          state_nxt = MRS_ST_INSTOP; // RQ18
        end else if (one_run) begin
          state_nxt = MRS_ST_RUN;
        end else if (spd_r == 16'h0000) begin
          state_nxt = decel_ctrl_en ? MRS_ST_HOLD : MRS_ST_IDLE; // RQ6
        end
      end
      MRS_ST_INSTOP: begin
        if (tick && tmr_r == 9'(`MRS_INSTOP_MS - 1)) begin // RQ8
          state_nxt = decel_ctrl_en ? MRS_ST_HOLD : MRS_ST_IDLE; // RQ6
        end
      end
      MRS_ST_HOLD: begin
        if (tick && tmr_r == 9'(`MRS_BRAKE_HOLD_MS - 1)) begin // RQ6
          state_nxt = MRS_ST_IDLE;
        end
      end
      default: begin
        state_nxt = MRS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= MRS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state_nxt != state_r) begin
      tmr_r <= 9'h000;
    end else if (tick) begin
      tmr_r <= tmr_r + 9'h001;
    end
  end

  // Direction flips only at standstill
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dir_r <= 1'b0;
    end else if (one_run && spd_r == 16'h0000) begin
      dir_r <= req_dir; // RQ5
    end
  end

  // ----------------------------------------------------------------
  // Ramp engine
  // ----------------------------------------------------------------
  // Each tick adds the slope numerator; the cycles in between drain it one r/min per
  // cycle against the ramp time in ms, which avoids a divider.
  mrs_rpm_t goal;
  mrs_rpm_t goal_r;
  mrs_rpm_t num_r;
  mrs_time_t tsel;
  logic [15:0] den;
  logic [23:0] acc_r;

  assign goal = (state_r == MRS_ST_RUN && dir_r == req_dir) ? tgt_rpm : 16'h0000;
  assign tsel = clamp_time((spd_r < goal) ? entry_accel[sel] : entry_decel[sel], decel_ctrl_en);
  assign den = 16'(tsel * `MRS_MS_PER_TENTH);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      goal_r <= 16'h0000;
      num_r <= 16'h0000;
    end else if (goal != goal_r) begin
      goal_r <= goal;
      if (remote) begin
        num_r <= `MRS_REMOTE_REF_RPM; // RQ4
      end else begin
        num_r <= (goal > spd_r) ? goal - spd_r : spd_r - goal; // RQ3
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state_r == MRS_ST_IDLE || state_r == MRS_ST_INSTOP || state_r == MRS_ST_HOLD) begin
      spd_r <= 16'h0000;
      acc_r <= 24'h000000;
    end else if (spd_r == goal_r) begin
      acc_r <= 24'h000000;
    end else if (den == 16'h0000) begin
      spd_r <= goal_r;
    end else if (tick) begin
      acc_r <= acc_r + {8'h00, num_r};
    end else if (acc_r >= {8'h00, den}) begin
      acc_r <= acc_r - {8'h00, den}; // RQ11 RQ13
      spd_r <= (spd_r < goal_r) ? spd_r + 16'h0001 : spd_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      speed_rpm <= 16'h0000;
      dir_reverse <= 1'b0;
      drive_on <= 1'b0;
      active_brake <= 1'b0;
      brake_release <= 1'b0;
      speed_regulate <= 1'b0;
      selected_entry <= 2'h0;
      state <= MRS_ST_IDLE;
      link.motor_running <= 1'b0;
    end else begin
      speed_rpm <= spd_r;
      dir_reverse <= dir_r;
      drive_on <= (state_r == MRS_ST_RUN) || (state_r == MRS_ST_DECEL);
      active_brake <= (state_r == MRS_ST_INSTOP); // RQ8
      // Brake free drops holding force even at standstill: unsafe for hanging loads
      brake_release <= f_free || (state_r == MRS_ST_RUN) || (state_r == MRS_ST_DECEL); // RQ9 RQ6
      speed_regulate <= decel_ctrl_en && (state_r == MRS_ST_RUN || state_r == MRS_ST_DECEL); // RQ14
      selected_entry <= sel;
      state <= state_r;
      link.motor_running <= (spd_r != 16'h0000);
    end
  end

endmodule

// *** test/mrs_link_props.sv ***
// Assertions on the controller-to-sequencer link and the stop and brake outputs
`include "mrs_params.svh"

module mrs_link_props #(
  parameter int TICK_CYCLES = `MRS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic data_select_bit0,
  input wire logic data_select_bit1,
  input wire logic brake_free_input,
  input wire logic motor_running,
  // Sequencer outputs
  input wire logic drive_on,
  input wire logic active_brake,
  input wire logic brake_release,
  input mrs_pkg::mrs_state_t state
);
  import mrs_pkg::*;
  // Tick counters start mid-tick, so one tick of slack
  localparam int MIN_HOLD = (`MRS_MIN_ON_MS - 1) * TICK_CYCLES;
  localparam int STOP_CYC = `MRS_INSTOP_MS * TICK_CYCLES;
  localparam int HOLD_CYC = `MRS_BRAKE_HOLD_MS * TICK_CYCLES;
  localparam int RUN_MIN = (`MRS_FILTER_MS - 1) * TICK_CYCLES;
  localparam int SETTLE = (`MRS_FILTER_MS + 3) * TICK_CYCLES;
  logic [4:0] link_now;
  logic [4:0] link_r;
  logic [31:0] quiet_r, brake_r, hold_r, one_r, both_r, free_r;

  function automatic logic [31:0] bump(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h1;
  endfunction

  assign link_now = {brake_free_input, data_select_bit1, data_select_bit0, reverse_run_input, forward_run_input};

  always_ff @(posedge clock) begin
    link_r <= resetn ? link_now : 5'h00;
  end
  always_ff @(posedge clock) begin
    quiet_r <= (!resetn || link_now != link_r) ? 32'h0 : bump(quiet_r);
  end
  always_ff @(posedge clock) begin
    brake_r <= (resetn && active_brake) ? bump(brake_r) : 32'h0;
  end
  always_ff @(posedge clock) begin
    hold_r <= (resetn && state == MRS_ST_HOLD) ? bump(hold_r) : 32'h0;
  end
  always_ff @(posedge clock) begin
    one_r <= (resetn && (forward_run_input ^ reverse_run_input)) ? bump(one_r) : 32'h0;
  end
  always_ff @(posedge clock) begin
    both_r <= (resetn && forward_run_input && reverse_run_input) ? bump(both_r) : 32'h0;
  end
  always_ff @(posedge clock) begin
    free_r <= (resetn && brake_free_input) ? bump(free_r) : 32'h0;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_stop_over;
    $fell(active_brake);
  endsequence
  sequence s_hold_over;
    $past(state) == MRS_ST_HOLD && state != MRS_ST_HOLD;
  endsequence
  sequence s_run_left;
    $past(state) == MRS_ST_RUN && state == MRS_ST_DECEL;
  endsequence

  chk_link_min_hold: assert property ((link_now != link_r) |-> quiet_r >= MIN_HOLD)
    else $error("link input changed too soon");
  chk_stop_length: assert property (s_stop_over |-> brake_r >= STOP_CYC - TICK_CYCLES && brake_r <= STOP_CYC + 2)
    else $error("active braking length wrong");
  chk_hold_length: assert property (s_hold_over |-> hold_r >= HOLD_CYC - TICK_CYCLES && hold_r <= HOLD_CYC + 2)
    else $error("brake hold length wrong");
  chk_both_stops: assert property (both_r == SETTLE |-> state != MRS_ST_RUN)
    else $error("both run inputs did not stop the motor");
  chk_start_filter: assert property ($rose(drive_on) |-> one_r >= RUN_MIN)
    else $error("run accepted before filter time");
  chk_free_release: assert property (free_r >= SETTLE |-> brake_release)
    else $error("brake not released on free input");
  chk_drive_unbraked: assert property (drive_on |-> brake_release && !active_brake)
    else $error("brake engaged while driving");
  chk_decel_release: assert property (s_run_left |-> !forward_run_input && !reverse_run_input)
    else $error("deceleration without run release");
  chk_idle_still: assert property ((state == MRS_ST_IDLE) [*3] |-> !motor_running)
    else $error("motor running while idle");
endmodule

// *** test/test_motor_run_ramp_sequencer.sv ***
// Bench joining controller and sequencer over the discrete link
module test_motor_run_ramp_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import mrs_pkg::*;
  // Short timebase keeps the millisecond counts fast
  // Under 13 cycles a tick cannot hold the steepest ramp's 12 steps between ticks
  localparam int T = 20;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic decel_ctrl_en = 1'b1;
  logic dir_swap = 1'b0;
  logic ext_speed_en = 1'b0;
  logic ramp_down_stop_mode = 1'b1;
  mrs_rpm_t entry_speed [4] = '{16'h012C, 16'h0258, 16'h0384, 16'h04B0};
  mrs_time_t entry_accel [4] = '{8'h02, 8'h02, 8'h04, 8'h01};
  mrs_time_t entry_decel [4] = '{8'h02, 8'h02, 8'h02, 8'h02};
  mrs_rpm_t ext_speed_rpm = 16'h01F4;
  mrs_rpm_t speed_rpm;
  mrs_sel_t selected_entry;
  mrs_state_t state;
  logic dir_reverse, drive_on, active_brake, brake_release, speed_regulate;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  mrs_link_if link();
  mrs_controller #(.TICK_CYCLES(T)) mrs_controller_inst (.link(link), .*);
  mrs_device #(.TICK_CYCLES(T)) mrs_device_inst (.link(link), .*);
  mrs_link_props #(.TICK_CYCLES(T)) mrs_link_props_inst (.clock, .resetn,
    .forward_run_input(link.forward_run_input), .reverse_run_input(link.reverse_run_input),
    .data_select_bit0(link.data_select_bit0), .data_select_bit1(link.data_select_bit1),
    .brake_free_input(link.brake_free_input), .motor_running(link.motor_running),
    .drive_on, .active_brake, .brake_release, .state);

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Checks and bus cycles
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic near(input int got, input int exp);
    comparisons++;
    if (got > exp + 2 * T || got < exp - 2 * T) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clock);
    while (!s_axi_awready) @(posedge clock);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid) @(posedge clock);
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clock);
    while (!s_axi_arready) @(posedge clock);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clock);
    cmp(s_axi_rdata, ed);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  // Counts only the moving part of a ramp
  task automatic ramp(input mrs_rpm_t goal, output int n);
    mrs_rpm_t s0;
    s0 = speed_rpm;
    n = 0;
    while (speed_rpm === s0) @(negedge clock);
    while (speed_rpm !== goal) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic stay(input mrs_state_t s, output int n);
    n = 0;
    while (state !== s) @(negedge clock);
    while (state === s) begin
      @(negedge clock);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    rd(4'h0, 32'h0, 2'h0);
    rd(4'hC, 32'h0, 2'h2);
    wr(4'h8, 32'h1, 2'h2);
    wr(4'h0, 32'hFFFF_FFF0, 2'h0);
    // Low byte lane off: the command must keep its value
    s_axi_wstrb <= 4'hE;
    wr(4'h0, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(4'h0, 32'h10, 2'h0);
    rd(4'h4, 32'h100, 2'h0);
    cmp1(brake_release, 1'b0);
    while (!brake_release) @(negedge clock);
    wr(4'h0, 32'h0, 2'h0);
    repeat (20 * T) @(negedge clock);
    cmp1(brake_release, 1'b0);
    $display("test_regs done");
  endtask
  task automatic test_panel();
    int n;
    wr(4'h0, 32'h5, 2'h0);
    ramp(16'h0258, n);
    near(n, 200 * T);
    cmp({30'h0, selected_entry}, 32'h1);
    rd(4'h4, 32'h205, 2'h0);
    cmp1(dir_reverse, 1'b0);
    cmp1(speed_regulate, 1'b1);
    wr(4'h0, 32'h9, 2'h0);
    ramp(16'h0384, n);
    near(n, 400 * T);
    cmp({30'h0, selected_entry}, 32'h2);
    wr(4'h0, 32'h0, 2'h0);
    ramp(16'h0000, n);
    near(n, 200 * T);
    stay(MRS_ST_HOLD, n);
    near(n, 100 * T);
    $display("test_panel done");
  endtask
  task automatic test_remote();
    int n;
    @(posedge clock);
    ext_speed_en <= 1'b1;
    dir_swap <= 1'b1;
    wr(4'h0, 32'h2, 2'h0);
    ramp(16'h01F4, n);
    near(n, 100 * T);
    cmp1(dir_reverse, 1'b0);
    wr(4'h0, 32'h3, 2'h0);
    stay(MRS_ST_INSTOP, n);
    near(n, 400 * T);
    cmp({29'h0, state}, {29'h0, MRS_ST_HOLD});
    wr(4'h0, 32'h0, 2'h0);
    while (state !== MRS_ST_IDLE) @(negedge clock);
    $display("test_remote done");
  endtask
  task automatic test_decel_off();
    int n;
    @(posedge clock);
    decel_ctrl_en <= 1'b0;
    ext_speed_en <= 1'b0;
    wr(4'h0, 32'hD, 2'h0);
    ramp(16'h04B0, n);
    near(n, 100 * T);
    cmp1(dir_reverse, 1'b1);
    cmp1(speed_regulate, 1'b0);
    wr(4'h0, 32'hC, 2'h0);
    ramp(16'h0000, n);
    repeat (2) @(negedge clock);
    cmp({29'h0, state}, {29'h0, MRS_ST_IDLE});
    $display("test_decel_off done");
  endtask
  task automatic test_clamp();
    int n;
    @(posedge clock);
    decel_ctrl_en <= 1'b1;
    ramp_down_stop_mode <= 1'b0;
    wr(4'h0, 32'hD, 2'h0);
    ramp(16'h04B0, n);
    near(n, 200 * T);
    wr(4'h0, 32'hC, 2'h0);
    while (drive_on) @(negedge clock);
    // Speed output trails the drive flag by one cycle
    @(negedge clock);
    cmp(32'(speed_rpm), 32'h0);
    $display("test_clamp done");
  endtask

  task automatic finish_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    test_regs();
    test_panel();
    test_remote();
    test_decel_off();
    test_clamp();
    finish_test();
  end
endmodule
